// ==== logic/rtaar_alias_remap.sv ====
`timescale 1ns/1ps
// Function
// RQ1: Physical slot bits 7:1 replace the address of a matched transaction.
// RQ2: Alias slot bits 7:1 compared with each incoming local address.
// RQ3: Alias slot n remaps to physical slot n.
// RQ4: Alias field zero disables the slot; no match, no access.
// RQ5: Alias bit 0 set acknowledges writes regardless of lock or remote ack.
// RQ6: Port select at 0x4c picks which port copy the registers reach.
// RQ7: All slot registers reset to 0x00.
// RQ8: Eight slot pairs per port, all compared in parallel.
module rtaar_alias_remap #(
  parameter int PORTS = 4,
  parameter int SLOTS = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic addr_valid,
  input wire logic [1:0] addr_port,
  input wire logic [6:0] addr_in,
  input wire logic addr_is_read,
  input wire logic fwd_locked,
  input wire logic remote_ack,
  output logic fwd_valid,
  output logic [6:0] fwd_addr,
  output logic fwd_is_read,
  output logic [2:0] fwd_slot,
  output logic local_ack
);
  if (PORTS < 1 || PORTS > 4 || SLOTS != 8)
  begin : g_bad_params
    $error("unsupported PORTS or SLOTS");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] port_sel;
    logic [7:0] rdata;
    logic fwd_valid;
    logic [6:0] fwd_addr;
    logic fwd_is_read;
    logic [2:0] fwd_slot;
    logic auto_ack;
  } rtaar_state_t;

  rtaar_state_t state_ff;
  rtaar_state_t nxt_state;

  logic [PORTS-1:0][SLOTS*8-1:0] phys_all;
  logic [PORTS-1:0][SLOTS*8-1:0] alias_all;
  logic [1:0] sel_port;
  logic is_phys;
  logic is_alias;
  logic [2:0] reg_slot;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  assign sel_port = state_ff.port_sel[1:0]; // [RQ6]
  assign is_phys = reg_addr == rtaar_pkg::PHYS_SLOT6_OFS || reg_addr == rtaar_pkg::PHYS_SLOT7_OFS;
  assign is_alias = reg_addr == rtaar_pkg::ALIAS_SLOT0_OFS
                    || reg_addr == rtaar_pkg::ALIAS_SLOT1_OFS;
  always_comb
  begin
    reg_slot = 3'h0;
    if (is_phys)
    begin
      reg_slot = 3'(reg_addr - rtaar_pkg::PHYS_BASE_OFS);
    end
    else if (is_alias)
    begin
      reg_slot = 3'(reg_addr - rtaar_pkg::ALIAS_BASE_OFS);
    end
  end
  assign reg_hit = is_phys || is_alias || reg_addr == rtaar_pkg::PORT_SEL_OFS;

  // ------------------------------------------------------------
  // Per port slot storage
  // ------------------------------------------------------------
  for (genvar p = 0; p < PORTS; p++)
  begin : g_port
    rtaar_port_regs #(
      .SLOTS(SLOTS)
    ) u_regs (
      .clock(clock),
      .reset(reset),
      .wr_phys(reg_wr && is_phys && sel_port == 2'(p)), // [RQ6]
      .wr_alias(reg_wr && is_alias && sel_port == 2'(p)), // [RQ6]
      .slot(reg_slot),
      .wdata(reg_wdata),
      .phys_flat(phys_all[p]),
      .alias_flat(alias_all[p])
    );
  end

  // ------------------------------------------------------------
  // Match and remap
  // ------------------------------------------------------------
  logic [SLOTS-1:0] hit_vec;
  logic [7:0] hit_alias;
  logic [7:0] hit_phys;
  logic [2:0] hit_slot;
  logic any_hit;
  logic [SLOTS*8-1:0] port_alias;
  logic [SLOTS*8-1:0] port_phys;

  assign port_alias = alias_all[addr_port];
  assign port_phys = phys_all[addr_port];

  always_comb
  begin
    hit_vec = '0;
    hit_alias = 8'h00;
    hit_phys = 8'h00;
    hit_slot = 3'h0;
    for (int s = 0; s < SLOTS; s++)
    begin
      hit_vec[s] = port_alias[s*8+1 +: 7] != rtaar_pkg::ALIAS_DISABLED // [RQ4]
                   && port_alias[s*8+1 +: 7] == addr_in; // [RQ2] [RQ8]
    end
    for (int s = SLOTS - 1; s >= 0; s--)
    begin
      if (hit_vec[s])
      begin
        hit_alias = port_alias[s*8 +: 8];
        hit_phys = port_phys[s*8 +: 8]; // [RQ3]
        hit_slot = 3'(s);
      end
    end
  end
  assign any_hit = |hit_vec;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.fwd_valid = 1'b0;
    nxt_state.auto_ack = 1'b0;
    if (reg_wr && reg_addr == rtaar_pkg::PORT_SEL_OFS)
    begin
      nxt_state.port_sel = reg_wdata; // [RQ6]
    end
    if (reg_rd)
    begin
      if (reg_addr == rtaar_pkg::PORT_SEL_OFS)
      begin
        nxt_state.rdata = state_ff.port_sel;
      end
      else if (is_phys)
      begin
        nxt_state.rdata = phys_all[sel_port][reg_slot*8 +: 8]; // [RQ6]
      end
      else if (is_alias)
      begin
        nxt_state.rdata = alias_all[sel_port][reg_slot*8 +: 8];
      end
      else
      begin
        nxt_state.rdata = 8'h00;
      end
    end
    if (addr_valid && any_hit)
    begin
      nxt_state.fwd_valid = 1'b1;
      nxt_state.fwd_addr = hit_phys[rtaar_pkg::ADDR_FIELD_MSB:rtaar_pkg::ADDR_FIELD_LSB]; // [RQ1]
      nxt_state.fwd_is_read = addr_is_read;
      nxt_state.fwd_slot = hit_slot;
      nxt_state.auto_ack = hit_alias[rtaar_pkg::AUTO_ACK_BIT] && !addr_is_read; // [RQ5]
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_ff <= '{port_sel: rtaar_pkg::PORT_SEL_RESET, default: '0};
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata = state_ff.rdata;
  assign fwd_valid = state_ff.fwd_valid;
  assign fwd_addr = state_ff.fwd_addr;
  assign fwd_is_read = state_ff.fwd_is_read;
  assign fwd_slot = state_ff.fwd_slot;
  assign local_ack = state_ff.auto_ack // [RQ5]
                     || (state_ff.fwd_valid && fwd_locked && remote_ack);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_REMAP_ADDR: assert property (@(posedge clock) disable iff (reset) // [RQ1]
    addr_valid && any_hit |=> fwd_valid && fwd_addr == $past(hit_phys[7:1]))
    else $error("remapped address wrong");
  AST_NO_HIT_NO_FWD: assert property (@(posedge clock) disable iff (reset) // [RQ2]
    !(addr_valid && any_hit) |=> !fwd_valid)
    else $error("forward without alias match");
  AST_SLOT_INDEX: assert property (@(posedge clock) disable iff (reset) // [RQ3]
    fwd_valid |-> fwd_addr == phys_all[$past(addr_port)][fwd_slot*8+1 +: 7]
    || $past(reg_wr))
    else $error("physical slot index differs from alias slot");
  AST_ZERO_DISABLED: assert property (@(posedge clock) disable iff (reset) // [RQ4]
    addr_in == 7'h00 |-> !any_hit)
    else $error("zero alias matched");
  AST_AUTO_ACK: assert property (@(posedge clock) disable iff (reset) // [RQ5]
    addr_valid && any_hit && hit_alias[0] && !addr_is_read |=> local_ack)
    else $error("auto acknowledge missing");
  AST_NO_AUTO_READ: assert property (@(posedge clock) disable iff (reset) // [RQ5]
    addr_valid && addr_is_read |=> !state_ff.auto_ack)
    else $error("auto acknowledge on read");
  AST_PORT_SEL: assert property (@(posedge clock) disable iff (reset) // [RQ6]
    reg_wr && reg_addr == rtaar_pkg::PORT_SEL_OFS |=> sel_port == $past(reg_wdata[1:0]))
    else $error("port select not stored");
  AST_PARALLEL: assert property (@(posedge clock) disable iff (reset) // [RQ8]
    any_hit |-> port_alias[hit_slot*8+1 +: 7] == addr_in)
    else $error("hit slot does not match address");
endmodule : rtaar_alias_remap

// ==== logic/rtaar_pkg.sv ====
package rtaar_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PHYS_BASE_OFS = 8'h5d;
  localparam logic [7:0] ALIAS_BASE_OFS = 8'h65;
  localparam logic [7:0] PORT_SEL_OFS = 8'h4c;
  localparam logic [7:0] PHYS_SLOT6_OFS = 8'h63;
  localparam logic [7:0] PHYS_SLOT7_OFS = 8'h64;
  localparam logic [7:0] ALIAS_SLOT0_OFS = 8'h65;
  localparam logic [7:0] ALIAS_SLOT1_OFS = 8'h66;
  // ------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------
  localparam int ADDR_FIELD_LSB = 1;
  localparam int ADDR_FIELD_MSB = 7;
  localparam int AUTO_ACK_BIT = 0;
  localparam logic [7:0] SLOT_RESET = 8'h00;
  localparam logic [7:0] PORT_SEL_RESET = 8'h00;
  localparam logic [6:0] ALIAS_DISABLED = 7'h00;
endpackage : rtaar_pkg

// ==== logic/rtaar_port_regs.sv ====
`timescale 1ns/1ps
module rtaar_port_regs #(
  parameter int SLOTS = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic wr_phys,
  input wire logic wr_alias,
  input wire logic [2:0] slot,
  input wire logic [7:0] wdata,
  output logic [SLOTS*8-1:0] phys_flat,
  output logic [SLOTS*8-1:0] alias_flat
);
  if (SLOTS < 1 || SLOTS > 8)
  begin : g_bad_slots
    $error("unsupported SLOTS");
  end

  typedef struct packed {
    logic [SLOTS*8-1:0] phys;
    logic [SLOTS*8-1:0] alias_r;
  } rtaar_regs_t;

  rtaar_regs_t state_ff;
  rtaar_regs_t nxt_state;

  always_comb
  begin
    nxt_state = state_ff;
    if (wr_phys)
    begin
      nxt_state.phys[slot*8 +: 8] = {wdata[rtaar_pkg::ADDR_FIELD_MSB:rtaar_pkg::ADDR_FIELD_LSB],
                                     1'b0};
    end
    if (wr_alias)
    begin
      nxt_state.alias_r[slot*8 +: 8] = wdata;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_ff.phys <= {SLOTS{rtaar_pkg::SLOT_RESET}}; // [RQ7]
      state_ff.alias_r <= {SLOTS{rtaar_pkg::SLOT_RESET}}; // [RQ7]
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign phys_flat = state_ff.phys;
  assign alias_flat = state_ff.alias_r;

  AST_RESET_CLEARS: assert property (@(posedge clock) // [RQ7]
    reset |=> alias_flat == '0 && phys_flat == '0)
    else $error("slot registers not cleared by reset");
endmodule : rtaar_port_regs

// ==== verif/rtaar_remote_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Remote target stand-in
// ------------------------------------------------------------
module rtaar_remote_model (
  input wire logic fwd_valid,
  input wire logic refuse,
  output logic remote_ack
);
  // Acks only a forwarded address, refuses on command
  assign remote_ack = fwd_valid & ~refuse;
endmodule : rtaar_remote_model

// ==== verif/i2c_remote_target_alias_remap_test.sv ====
`timescale 1ns/1ps
module i2c_remote_target_alias_remap_test;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, addr_valid = 1'b0, addr_is_read = 1'b0;
  logic fwd_locked = 1'b0, refuse = 1'b0, remote_ack;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] addr_port = 2'h0;
  logic [6:0] addr_in = 7'h00, fwd_addr;
  logic [2:0] fwd_slot;
  logic reg_hit, fwd_valid, fwd_is_read, local_ack;
  int miscompares = 0;
  int n_tests = 0;
  always #12.5 clock = ~clock;
  rtaar_alias_remap i_rtaar_alias_remap (.clock(clock), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .addr_valid(addr_valid), .addr_port(addr_port), .addr_in(addr_in),
    .addr_is_read(addr_is_read), .fwd_locked(fwd_locked), .remote_ack(remote_ack),
    .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_is_read(fwd_is_read),
    .fwd_slot(fwd_slot), .local_ack(local_ack));
  rtaar_remote_model i_rtaar_remote_model (.fwd_valid(fwd_valid), .refuse(refuse),
    .remote_ack(remote_ack));
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic step;
    @(posedge clock);
    #1;
  endtask : step
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic h);
    reg_addr = a;
    reg_rd = 1'b1;
    #1;
    check({7'h00, reg_hit}, {7'h00, h});
    step;
    reg_rd = 1'b0;
    check(reg_rdata, exp);
    step;
  endtask : rd
  task automatic look(input logic [1:0] p, input logic [6:0] a, input logic r,
    input logic v, input logic [2:0] s, input logic k);
    addr_port = p;
    addr_in = a;
    addr_is_read = r;
    addr_valid = 1'b1;
    step;
    addr_valid = 1'b0;
    check({7'h00, fwd_valid}, {7'h00, v});
    if (v)
    begin
      check({5'h00, fwd_slot}, {5'h00, s});
      check({1'b0, fwd_addr}, 8'h00);
      check({7'h00, fwd_is_read}, {7'h00, r});
    end
    check({7'h00, local_ack}, {7'h00, k});
    step;
  endtask : look
  task automatic conclude;
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge clock);
    miscompares++;
    conclude;
  end
  initial
  begin
    repeat (12) @(posedge clock);
    #1;
    reset = 1'b0;
    rd(8'h63, 8'h00, 1'b1);
    rd(8'h64, 8'h00, 1'b1);
    rd(8'h65, 8'h00, 1'b1);
    rd(8'h66, 8'h00, 1'b1);
    rd(8'h70, 8'h00, 1'b0);
    look(2'h0, 7'h00, 1'b0, 1'b0, 3'h0, 1'b0);
    wr(8'h63, 8'ha5);
    rd(8'h63, 8'ha4, 1'b1);
    wr(8'h64, 8'hff);
    rd(8'h64, 8'hfe, 1'b1);
    wr(8'h65, 8'h43);
    rd(8'h65, 8'h43, 1'b1);
    wr(8'h66, 8'h44);
    rd(8'h66, 8'h44, 1'b1);
    look(2'h0, 7'h21, 1'b0, 1'b1, 3'h0, 1'b1);
    look(2'h0, 7'h21, 1'b1, 1'b1, 3'h0, 1'b0);
    look(2'h0, 7'h22, 1'b0, 1'b1, 3'h1, 1'b0);
    look(2'h0, 7'h23, 1'b0, 1'b0, 3'h0, 1'b0);
    fwd_locked = 1'b1;
    look(2'h0, 7'h22, 1'b0, 1'b1, 3'h1, 1'b1);
    refuse = 1'b1;
    look(2'h0, 7'h22, 1'b0, 1'b1, 3'h1, 1'b0);
    look(2'h0, 7'h21, 1'b0, 1'b1, 3'h0, 1'b1);
    wr(8'h66, 8'h42);
    look(2'h0, 7'h21, 1'b1, 1'b1, 3'h0, 1'b0);
    wr(8'h4c, 8'h01);
    rd(8'h65, 8'h00, 1'b1);
    look(2'h1, 7'h21, 1'b0, 1'b0, 3'h0, 1'b0);
    wr(8'h65, 8'h60);
    look(2'h1, 7'h30, 1'b0, 1'b1, 3'h0, 1'b0);
    look(2'h0, 7'h30, 1'b0, 1'b0, 3'h0, 1'b0);
    reset = 1'b1;
    step;
    reset = 1'b0;
    rd(8'h4c, 8'h00, 1'b1);
    rd(8'h66, 8'h00, 1'b1);
    look(2'h0, 7'h21, 1'b0, 1'b0, 3'h0, 1'b0);
    conclude;
  end
endmodule : i2c_remote_target_alias_remap_test
